// ===== bench/rmc_host.sv
// rmc_host: two-wire bus master in the place of the host processor
`timescale 1ns/1ps

module rmc_host #(
	parameter logic [6:0] DEV = 7'h2A
) (
	// clock
	input  wire logic clk,
	// bus wires
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// 8 clk per third of a bit keeps edges well apart for the synchronisers
	task automatic tick();
		repeat (8) @(posedge clk);
	endtask : tick

	task automatic xbit(input logic b, output logic r);
		sda_low <= ~b;
		tick();
		scl <= 1'b1;
		tick();
		r = sda;
		scl <= 1'b0;
		tick();
	endtask : xbit

	// serves as a repeated start too, since it first raises both lines
	task automatic start();
		sda_low <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_low <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask : start

	task automatic stop();
		sda_low <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_low <= 1'b0;
		tick();
	endtask : stop

	task automatic xbyte(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], q[i]);
		xbit(ai, ao);
	endtask : xbyte

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic nak, input logic [6:0] dev = DEV);
		logic [7:0] q;
		logic [2:0] k;
		start();
		xbyte({dev, 1'b0}, 1'b1, q, k[0]);
		xbyte(a, 1'b1, q, k[1]);
		xbyte(d, 1'b1, q, k[2]);
		stop();
		nak = |k;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start();
		xbyte({DEV, 1'b0}, 1'b1, q, k);
		xbyte(a, 1'b1, q, k);
		start();
		xbyte({DEV, 1'b1}, 1'b1, q, k);
		xbyte(8'hFF, 1'b1, d, k);
		stop();
	endtask : rd
endmodule : rmc_host

// ===== bench/rmc_top_sva.sv
// rmc_top_sva: port checks for the mode config block
`timescale 1ns/1ps

module rmc_top_sva (
	// clock and reset
	input wire logic               clk,
	input wire logic               reset,
	input wire logic               ce,
	// bus pins
	input wire logic               scl_in,
	input wire logic               sda_in,
	input wire logic               sda_out,
	input wire logic               sda_oe,
	// fuse and controls
	input wire rmc_pkg::rmc_fuse_t fuse,
	input wire rmc_pkg::rmc_ctrl_t ctrl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_FUSE_LOAD: assert property (
		$fell(reset) |-> ##[1:3]
		(ctrl.light_load_enable == fuse.sw_mode[5:0] &&
		ctrl.sequencer_select == fuse.order_sel[6:0]))
		else $error("fuse defaults not loaded");
	AST_EDGE_ZERO: assert property (
		$fell(reset) |-> (ctrl.edge_rate_reduce == 6'h00) [*8])
		else $error("edge rate not zero after reset");
	AST_CODE_HELD: assert property (
		ctrl.ch6_step_down_only |-> ctrl.ch6_kick_in_threshold_code == 2'h0)
		else $error("kick-in code used in step-down mode");
	AST_BOOST_MODE: assert property (
		!$past(reset) |-> ctrl.ch6_boost_active != ctrl.ch6_step_down_only)
		else $error("channel 6 mode outputs disagree");
	AST_CODE_BOOST: assert property (
		ctrl.ch6_kick_in_threshold_code != 2'h0 |-> ctrl.ch6_boost_active)
		else $error("kick-in code without boost");
	// a write lands only in the low phase after the last data bit
	AST_WRITE_TIME: assert property (
		$changed(ctrl) && !$past(reset, 3) |-> !scl_in && !$past(scl_in, 3))
		else $error("control changed outside a write slot");
	AST_SETTLE: assert property (
		$changed(ctrl) && !$past(reset, 2) |=> $stable(ctrl) [*8])
		else $error("control changed twice in one byte");
	AST_ACK_SLOT: assert property (
		$rose(sda_oe) |-> !scl_in && !sda_out)
		else $error("acknowledge driven in clock high phase");
	// a low enable must hold ctrl and sda_oe where they stand
	AST_FREEZE: assert property (
		!ce |=> $stable(ctrl) && $stable(sda_oe))
		else $error("outputs moved while clock enable low");
endmodule : rmc_top_sva

bind rmc_top rmc_top_sva u_sva (.clk(clk), .reset(reset), .ce(ce),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .fuse(fuse), .ctrl(ctrl));

// ===== bench/rmc_top_tb.sv
// rmc_top_tb: register tests of the mode config block over two wires
`timescale 1ns/1ps

module rmc_top_tb;
	logic               clk;
	logic               reset;
	logic               ce;
	logic               scl;
	logic               sda_low;
	logic               sda_oe;
	logic               sda_out;
	wire logic          sda;
	rmc_pkg::rmc_fuse_t fuse;
	rmc_pkg::rmc_ctrl_t ctrl;
	int                 miscompares;
	int                 compares;
	logic [7:0]         q;
	logic               nak;

	// pull-up: low while either side pulls
	assign sda = ~(sda_low | sda_oe);

	rmc_top u_dut (.clk(clk), .reset(reset), .ce(ce), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .fuse(fuse),
		.ctrl(ctrl));
	rmc_host #(.DEV(rmc_pkg::DEV_ADDR_DEF)) u_host (.clk(clk), .sda(sda),
		.scl(scl), .sda_low(sda_low));

	task automatic chk(input string s, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rchk

	task automatic wchk(input logic [7:0] a, input logic [7:0] d);
		u_host.wr(a, d, nak);
		chk("ack", 8'h00, {7'h00, nak});
	endtask : wchk

	task automatic do_reset(input rmc_pkg::rmc_fuse_t f);
		fuse <= f;
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		fuse = 24'h000000;
		miscompares = 0;
		compares = 0;
		do_reset(24'hFFFFFF);
		rchk(8'h1C, 8'h3F);
		rchk(8'h1D, 8'h7F);
		rchk(8'h1E, 8'h13);
		rchk(8'h1F, 8'h00);
		$display("test fuse ones end");
		// light-load reads back 0x2A with bits 1, 3 and 5 set, and bits outside each mask read back zero
		wchk(8'h1C, 8'hAA);
		wchk(8'h1D, 8'hD5);
		wchk(8'h1F, 8'hFF);
		rchk(8'h1C, 8'h2A);
		rchk(8'h1D, 8'h55);
		rchk(8'h1F, 8'h3F);
		chk("light", 8'h2A, {2'h0, ctrl.light_load_enable});
		chk("seq", 8'h55, {1'h0, ctrl.sequencer_select});
		chk("edge", 8'h3F, {2'h0, ctrl.edge_rate_reduce});
		$display("test write end");
		for (int c = 0; c < 4; c++) begin
			wchk(8'h1E, 8'(c) | 8'hEC);
			rchk(8'h1E, 8'(c));
			chk("code", 8'(c), {6'h00, ctrl.ch6_kick_in_threshold_code});
			chk("boost", 8'h01, {7'h00, ctrl.ch6_boost_active});
			chk("step", 8'h00, {7'h00, ctrl.ch6_step_down_only});
		end
		wchk(8'h1E, 8'h13);
		rchk(8'h1E, 8'h13);
		chk("step", 8'h01, {7'h00, ctrl.ch6_step_down_only});
		chk("no boost", 8'h00, {7'h00, ctrl.ch6_boost_active});
		chk("held", 8'h00, {6'h00, ctrl.ch6_kick_in_threshold_code});
		$display("test channel 6 end");
		u_host.wr(8'h1C, 8'h00, nak, 7'h15);
		chk("foreign", 8'h01, {7'h00, nak});
		rchk(8'h1C, 8'h2A);
		wchk(8'h40, 8'hFF);
		rchk(8'h40, 8'h00);
		$display("test refusal end");
		// frozen device must neither answer nor store the write
		ce <= 1'b0;
		u_host.wr(8'h1F, 8'h00, nak);
		chk("frozen", 8'h01, {7'h00, nak});
		ce <= 1'b1;
		rchk(8'h1F, 8'h3F);
		chk("edge", 8'h3F, {2'h0, ctrl.edge_rate_reduce});
		$display("test clock enable end");
		do_reset(24'h0115C5);
		rchk(8'h1C, 8'h05);
		rchk(8'h1D, 8'h15);
		rchk(8'h1E, 8'h01);
		rchk(8'h1F, 8'h00);
		chk("code", 8'h01, {6'h00, ctrl.ch6_kick_in_threshold_code});
		$display("test second reset end");
		give_verdict();
	end
endmodule : rmc_top_tb

// ===== rtl/rmc_bank.sv
// rmc_bank: the four configuration registers and their control outputs
`timescale 1ns/1ps

module rmc_bank (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	// factory defaults
	input  wire rmc_pkg::rmc_fuse_t fuse,
	// register access
	input  wire rmc_pkg::rmc_wr_t   wr,
	input  wire logic [7:0]         rd_addr,
	output logic [7:0]              rd_data,
	// regulator controls
	output rmc_pkg::rmc_ctrl_t      ctrl
);

	// ------------------------------------------------------------------
	// address decode: {hit, index}
	// ------------------------------------------------------------------
	function automatic logic [2:0] rmc_decode(input logic [7:0] a);
		if (a == rmc_pkg::OFS_SW_MODE)
			rmc_decode = 3'h4;
		else if (a == rmc_pkg::OFS_ORDER)
			rmc_decode = 3'h5;
		else if (a == rmc_pkg::OFS_CH6)
			rmc_decode = 3'h6;
		else if (a == rmc_pkg::OFS_EDGE)
			rmc_decode = 3'h7;
		else
			rmc_decode = 3'h0;
	endfunction : rmc_decode

	logic [7:0]  reg_r [4];
	logic        load_pend_r;
	logic [2:0]  wr_dec;
	logic [2:0]  rd_dec;
	logic [31:0] fuse_vec;

	assign wr_dec   = rmc_decode(wr.addr);
	assign rd_dec   = rmc_decode(rd_addr);
	assign fuse_vec = {8'h00, fuse};

	// ------------------------------------------------------------------
	// fuse load one cycle after reset release; fuses cannot be caught
	// by the asynchronous reset itself
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			load_pend_r <= 1'b1;
		else if (ce)
			load_pend_r <= 1'b0;
	end

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_reg
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				reg_r[i] <= rmc_pkg::REG_RESETS[i*8 +: 8];
			end else if (ce) begin
				if (load_pend_r && rmc_pkg::REG_FUSED[i])
					reg_r[i] <= fuse_vec[i*8 +: 8]
						& rmc_pkg::REG_MASKS[i*8 +: 8];
				else if (wr.en && wr_dec[2] && wr_dec[1:0] == 2'(i))
					reg_r[i] <= wr.data
						& rmc_pkg::REG_MASKS[i*8 +: 8];
			end
		end
	end

	// unmapped offsets read zero
	assign rd_data = rd_dec[2] ? reg_r[rd_dec[1:0]] : 8'h00;

	// ------------------------------------------------------------------
	// registered controls toward the regulators
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= '0;
		end else if (ce) begin
			ctrl.light_load_enable <= reg_r[0][5:0];
			ctrl.sequencer_select  <= reg_r[1][6:0];
			ctrl.ch6_step_down_only <=
				reg_r[2][rmc_pkg::CH6_STEP_DOWN_BIT];
			ctrl.ch6_boost_active <=
				~reg_r[2][rmc_pkg::CH6_STEP_DOWN_BIT];
			// code is kept in the register but masked in step-down mode
			ctrl.ch6_kick_in_threshold_code <=
				reg_r[2][rmc_pkg::CH6_STEP_DOWN_BIT] ? 2'h0 :
				reg_r[2][rmc_pkg::CH6_CODE_LSB +: 2];
			ctrl.edge_rate_reduce <= reg_r[3][5:0];
		end
	end

endmodule : rmc_bank

// ===== rtl/rmc_pkg.sv
// rmc_pkg: shared constants and carriers for the regulator mode config block
package rmc_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_SW_MODE = 8'h1C;
	localparam logic [7:0] OFS_ORDER   = 8'h1D;
	localparam logic [7:0] OFS_CH6     = 8'h1E;
	localparam logic [7:0] OFS_EDGE    = 8'h1F;

	// ------------------------------------------------------------------
	// writable bit masks, unassigned bits read zero
	// ------------------------------------------------------------------
	localparam logic [7:0] MASK_SW_MODE = 8'h3F;
	localparam logic [7:0] MASK_ORDER   = 8'h7F;
	localparam logic [7:0] MASK_CH6     = 8'h13;
	localparam logic [7:0] MASK_EDGE    = 8'h3F;
	localparam logic [31:0] REG_MASKS   = {MASK_EDGE, MASK_CH6,
		MASK_ORDER, MASK_SW_MODE};

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int CH6_STEP_DOWN_BIT = 4;
	localparam int CH6_CODE_LSB      = 0;
	localparam int SW_CHANNELS       = 6;
	localparam int ORDER_CHANNELS    = 7;

	// ------------------------------------------------------------------
	// reset values; bit set in REG_FUSED means fuse-loaded after reset
	// ------------------------------------------------------------------
	localparam logic [7:0] RESET_EDGE  = 8'h00;
	localparam logic [7:0] RESET_OTHER = 8'h00;
	localparam logic [31:0] REG_RESETS = {RESET_EDGE, RESET_OTHER,
		RESET_OTHER, RESET_OTHER};
	localparam logic [3:0] REG_FUSED   = 4'h7;

	// ------------------------------------------------------------------
	// two-wire link
	// ------------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] DEV_ADDR_DEF  = 7'h2A; // arbitrary bus address

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ch6_mode;
		logic [7:0] order_sel;
		logic [7:0] sw_mode;
	} rmc_fuse_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} rmc_wr_t;

	typedef struct packed {
		logic [5:0] light_load_enable;
		logic [6:0] sequencer_select;
		logic       ch6_step_down_only;
		logic       ch6_boost_active;
		logic [1:0] ch6_kick_in_threshold_code;
		logic [5:0] edge_rate_reduce;
	} rmc_ctrl_t;

endpackage : rmc_pkg

// ===== rtl/rmc_top.sv
// rmc_top: two-wire register slave in front of the mode config registers
//
// Function
// - 0x1C bits 0-5 select light-load switching
// - 0x1D bits 0-6 select sequencer control
// - 0x1C-0x1E load fuse defaults after reset
// - 0x1E bit 4 selects channel 6 step-down only
// - 0x1E bits 1:0 hold boost threshold code
// - threshold code used only in buck-boost mode
// - 0x1F bits 0-5 select reduced edge rate
// - edge rate register resets to zero
`timescale 1ns/1ps

module rmc_top #(
	parameter logic [6:0] DEV_ADDR = rmc_pkg::DEV_ADDR_DEF
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	// two-wire bus pins
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	// factory defaults
	input  wire rmc_pkg::rmc_fuse_t fuse,
	// regulator controls
	output rmc_pkg::rmc_ctrl_t      ctrl
);

	// ------------------------------------------------------------------
	// state encoding
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} rmc_state_t;

	rmc_state_t       state_r;
	logic             scl_s1_r;
	logic             scl_s2_r;
	logic             scl_d_r;
	logic             sda_s1_r;
	logic             sda_s2_r;
	logic             sda_d_r;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_seen;
	logic             stop_seen;
	logic [3:0]       cnt_r;
	logic [7:0]       shift_r;
	logic [7:0]       ptr_r;
	logic [7:0]       tx_r;
	logic             rw_r;
	logic             ack_r;
	logic             byte_end;
	logic [7:0]       rd_data;
	rmc_pkg::rmc_wr_t wr_r;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else if (ce) begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	// ------------------------------------------------------------------
	// bus events, seen on the second synchroniser stage only
	// ------------------------------------------------------------------
	assign scl_rise   = scl_s2_r & ~scl_d_r;
	assign scl_fall   = ~scl_s2_r & scl_d_r;
	assign start_seen = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_seen  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	assign byte_end   = (cnt_r == rmc_pkg::BITS_PER_BYTE);

	// ------------------------------------------------------------------
	// byte engine; sda changes only after scl has been seen low, which
	// keeps our own drive from looking like a start or stop
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			shift_r <= 8'h00;
			ptr_r   <= 8'h00;
			tx_r    <= 8'h00;
			rw_r    <= 1'b0;
			ack_r   <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (ce) begin
			if (start_seen) begin
				state_r <= ST_ADDR;
				cnt_r   <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (stop_seen) begin
				state_r <= ST_IDLE;
				cnt_r   <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (scl_rise) begin
				case (state_r)
					ST_ADDR, ST_REG, ST_WR: begin
						shift_r <= {shift_r[6:0], sda_s2_r};
						cnt_r   <= cnt_r + 4'h1;
					end
					ST_RD: begin
						cnt_r <= cnt_r + 4'h1;
					end
					ST_RD_ACK: begin
						ack_r <= ~sda_s2_r;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_r)
					ST_ADDR: begin
						if (byte_end) begin
							cnt_r <= 4'h0;
							if (shift_r[7:1] == DEV_ADDR) begin
								state_r <= ST_ADDR_ACK;
								rw_r    <= shift_r[0];
								sda_oe  <= 1'b1;
							end else begin
								// not ours: wait for the next start
								state_r <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (rw_r) begin
							state_r <= ST_RD;
							tx_r    <= rd_data;
							sda_oe  <= ~rd_data[7];
						end else begin
							state_r <= ST_REG;
							sda_oe  <= 1'b0;
						end
					end
					ST_REG: begin
						if (byte_end) begin
							cnt_r   <= 4'h0;
							ptr_r   <= shift_r;
							state_r <= ST_REG_ACK;
							sda_oe  <= 1'b1;
						end
					end
					ST_REG_ACK, ST_WR_ACK: begin
						state_r <= ST_WR;
						sda_oe  <= 1'b0;
					end
					ST_WR: begin
						if (byte_end) begin
							cnt_r   <= 4'h0;
							ptr_r   <= ptr_r + 8'h01;
							state_r <= ST_WR_ACK;
							sda_oe  <= 1'b1;
						end
					end
					ST_RD: begin
						if (byte_end) begin
							cnt_r   <= 4'h0;
							ptr_r   <= ptr_r + 8'h01;
							state_r <= ST_RD_ACK;
							sda_oe  <= 1'b0;
						end else begin
							tx_r   <= {tx_r[6:0], 1'b0};
							sda_oe <= ~tx_r[6];
						end
					end
					ST_RD_ACK: begin
						if (ack_r) begin
							state_r <= ST_RD;
							tx_r    <= rd_data;
							sda_oe  <= ~rd_data[7];
						end else begin
							state_r <= ST_IDLE;
							sda_oe  <= 1'b0;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// write strobe, one cycle, taken at the data byte's eighth falling
	// edge; every byte is acknowledged, unmapped offsets simply drop it
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_r <= '0;
		end else if (ce) begin
			wr_r.en   <= scl_fall & ~start_seen & ~stop_seen
				& (state_r == ST_WR) & byte_end;
			wr_r.addr <= ptr_r;
			wr_r.data <= shift_r;
		end
	end

	// ------------------------------------------------------------------
	// open-drain data pin: only ever pulls low
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sda_out <= 1'b0;
		else if (ce)
			sda_out <= 1'b0;
	end

	// ------------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------------
	rmc_bank u_bank (
		.clk     (clk),
		.reset   (reset),
		.ce      (ce),
		.fuse    (fuse),
		.wr      (wr_r),
		.rd_addr (ptr_r),
		.rd_data (rd_data),
		.ctrl    (ctrl)
	);

endmodule : rmc_top
